/* File: mscu_capture.sv */
// motor servo capture unit: free-running and reference timer captures
// ============================================================
// Notes on behaviour
// - drum frequency pulse rising edge copies free running count into drum capture
// - drum capture load also pulses the drum capture interrupt request
// - capstan frequency pulse rising edge copies free running count into capstan capture
// - capstan capture load also pulses the capstan capture interrupt request
// - reference timer counts and clears on matching its period compare value
// - reference signal event loads free running count into reference capture
// - drum phase pulse event loads free running count into phase capture
// - in playback, control track pulse captures reference timer into control track capture
// - in recording, divided capstan pulse loads control track capture instead
`include "mscu_defs.svh"
module mscu_capture
  import mscu_pkg::*;
#(
  parameter int COUNT_W = `MSCU_COUNT_W
)
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire mscu_pulse_s pulse_in,
  input wire logic record_mode_in,
  input wire logic [COUNT_W-1:0] reference_period_compare_in,
  output logic [COUNT_W-1:0] free_running_count_out,
  output logic [COUNT_W-1:0] reference_timer_count_out,
  output logic [COUNT_W-1:0] drum_freq_capture_out,
  output logic [COUNT_W-1:0] capstan_freq_capture_out,
  output logic [COUNT_W-1:0] reference_capture_out,
  output logic [COUNT_W-1:0] phase_capture_out,
  output logic [COUNT_W-1:0] control_track_capture_out,
  output logic reference_signal_out,
  output logic drum_capture_irq_out,
  output logic capstan_capture_irq_out
);
  // ============================================================
  // state
  typedef struct packed {
    mscu_pulse_s pulse_prev;
    logic [COUNT_W-1:0] free_running_count;
    logic [COUNT_W-1:0] tmr;
    logic [COUNT_W-1:0] drum_cap;
    logic [COUNT_W-1:0] capstan_cap;
    logic [COUNT_W-1:0] ref_cap;
    logic [COUNT_W-1:0] phase_cap;
    logic [COUNT_W-1:0] ct_cap;
    logic ref_sig;
    logic drum_irq;
    logic capstan_irq;
  } mscu_state_s;

  mscu_state_s state_reg;
  mscu_state_s state_next;
  mscu_pulse_s rise;
  logic ref_match;
  localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

  // ============================================================
  // parameter check, refused at elaboration rather than at run time
  if (COUNT_W < 2 || COUNT_W > 32)
  begin : g_count_w_check
    $error("mscu_capture: COUNT_W out of range");
  end

  // ============================================================
  // edge detection, inputs are synchronous so one stage suffices
  // a level held high is one event: the next edge needs a low cycle first
  assign rise = pulse_in & ~state_reg.pulse_prev;
  assign ref_match = (state_reg.tmr == reference_period_compare_in);

  always_comb
  begin
    state_next = state_reg;
    state_next.pulse_prev = pulse_in;
    state_next.free_running_count = state_reg.free_running_count + COUNT_ONE;
    state_next.drum_irq = 1'b0;
    state_next.capstan_irq = 1'b0;
    state_next.ref_sig = ref_match;
    // a compare value below the count is only reached after wrap
    if (ref_match)
      state_next.tmr = '0;
    else
      state_next.tmr = state_reg.tmr + COUNT_ONE;
    if (rise.drum_freq)
    begin
      state_next.drum_cap = state_reg.free_running_count;
      state_next.drum_irq = 1'b1;
    end
    if (rise.capstan_freq)
    begin
      state_next.capstan_cap = state_reg.free_running_count;
      state_next.capstan_irq = 1'b1;
    end
    if (ref_match)
      state_next.ref_cap = state_reg.free_running_count;
    if (rise.drum_phase)
      state_next.phase_cap = state_reg.free_running_count;
    // the mode picks one track source, the other one is ignored
    if (!record_mode_in && rise.playback_ct)
      state_next.ct_cap = state_reg.tmr;
    else if (record_mode_in && rise.capstan_div)
      state_next.ct_cap = state_reg.tmr;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= '0;
      state_reg.free_running_count <= COUNT_W'(`MSCU_FRC_RESET);
      state_reg.tmr <= COUNT_W'(`MSCU_TIMER_RESET);
    end
    else
      state_reg <= state_next;
  end

  // ============================================================
  // outputs straight from flip-flops
  assign free_running_count_out = state_reg.free_running_count;
  assign reference_timer_count_out = state_reg.tmr;
  assign drum_freq_capture_out = state_reg.drum_cap;
  assign capstan_freq_capture_out = state_reg.capstan_cap;
  assign reference_capture_out = state_reg.ref_cap;
  assign phase_capture_out = state_reg.phase_cap;
  assign control_track_capture_out = state_reg.ct_cap;
  assign reference_signal_out = state_reg.ref_sig;
  assign drum_capture_irq_out = state_reg.drum_irq;
  assign capstan_capture_irq_out = state_reg.capstan_irq;

  // ============================================================
  // checks: captured values
  drum_capture_value_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (pulse_in.drum_freq && !$past(pulse_in.drum_freq)) |=> drum_freq_capture_out == $past(free_running_count_out))
    else $error("drum capture value wrong");
  drum_irq_pair_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    drum_capture_irq_out |-> drum_freq_capture_out == free_running_count_out - COUNT_ONE)
    else $error("drum irq without capture");
  capstan_capture_value_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (pulse_in.capstan_freq && !$past(pulse_in.capstan_freq))
      |=> capstan_freq_capture_out == $past(free_running_count_out))
    else $error("capstan capture value wrong");
  capstan_irq_pair_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    capstan_capture_irq_out |-> capstan_freq_capture_out == free_running_count_out - COUNT_ONE)
    else $error("capstan irq without capture");
  ref_timer_clear_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (reference_timer_count_out == reference_period_compare_in) |=> reference_timer_count_out == '0 && reference_signal_out)
    else $error("reference timer did not clear");
  ref_capture_load_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    reference_signal_out |-> reference_capture_out == free_running_count_out - COUNT_ONE)
    else $error("reference capture wrong");
  phase_capture_load_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (pulse_in.drum_phase && !$past(pulse_in.drum_phase)) |=> phase_capture_out == $past(free_running_count_out))
    else $error("phase capture wrong");
  ct_playback_load_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (!record_mode_in && pulse_in.playback_ct && !$past(pulse_in.playback_ct))
      |=> control_track_capture_out == $past(reference_timer_count_out))
    else $error("playback control track capture wrong");
  ct_record_load_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (record_mode_in && pulse_in.capstan_div && !$past(pulse_in.capstan_div))
      |=> control_track_capture_out == $past(reference_timer_count_out))
    else $error("record control track capture wrong");
  drum_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !(pulse_in.drum_freq && !$past(pulse_in.drum_freq)) |=> $stable(drum_freq_capture_out))
    else $error("drum capture changed without edge");

  // ============================================================
  // checks: counters
  // the compare input is sampled on the same edge as the timer, so a
  // compare change takes effect in the very cycle it is applied
  free_count_step_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    1'b1 |=> free_running_count_out == $past(free_running_count_out) + COUNT_ONE)
    else $error("free running count skipped");
  ref_timer_step_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (reference_timer_count_out != reference_period_compare_in)
      |=> reference_timer_count_out == $past(reference_timer_count_out) + COUNT_ONE)
    else $error("reference timer did not count");
  ref_signal_only_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (reference_timer_count_out != reference_period_compare_in) |=> !reference_signal_out)
    else $error("reference signal without match");
  ref_signal_pulse_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    reference_signal_out |-> reference_timer_count_out == '0)
    else $error("reference signal while timer not cleared");

  // ============================================================
  // checks: interrupt requests
  // each request stands one cycle per captured edge and never otherwise
  drum_irq_edge_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (pulse_in.drum_freq && !$past(pulse_in.drum_freq)) |=> drum_capture_irq_out)
    else $error("drum irq missing");
  drum_irq_only_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !(pulse_in.drum_freq && !$past(pulse_in.drum_freq)) |=> !drum_capture_irq_out)
    else $error("drum irq without edge");
  capstan_irq_edge_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (pulse_in.capstan_freq && !$past(pulse_in.capstan_freq)) |=> capstan_capture_irq_out)
    else $error("capstan irq missing");
  capstan_irq_only_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !(pulse_in.capstan_freq && !$past(pulse_in.capstan_freq)) |=> !capstan_capture_irq_out)
    else $error("capstan irq without edge");

  // ============================================================
  // checks: captures hold between events
  capstan_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !(pulse_in.capstan_freq && !$past(pulse_in.capstan_freq)) |=> $stable(capstan_freq_capture_out))
    else $error("capstan capture changed without edge");
  phase_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !(pulse_in.drum_phase && !$past(pulse_in.drum_phase)) |=> $stable(phase_capture_out))
    else $error("phase capture changed without edge");
  ref_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (reference_timer_count_out != reference_period_compare_in) |=> $stable(reference_capture_out))
    else $error("reference capture changed without event");
  ct_hold_a: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    !(!record_mode_in && pulse_in.playback_ct && !$past(pulse_in.playback_ct))
      && !(record_mode_in && pulse_in.capstan_div && !$past(pulse_in.capstan_div))
      |=> $stable(control_track_capture_out))
    else $error("control track capture changed without event");

  // ============================================================
  // covers for the main scenarios
  drum_irq_c: cover property (@(posedge clock_in) disable iff (!rst_b_in) drum_capture_irq_out);
  capstan_irq_c: cover property (@(posedge clock_in) disable iff (!rst_b_in) capstan_capture_irq_out);
  ref_event_c: cover property (@(posedge clock_in) disable iff (!rst_b_in) reference_signal_out);
  playback_ct_c: cover property (@(posedge clock_in) disable iff (!rst_b_in) !record_mode_in && rise.playback_ct);
  record_ct_c: cover property (@(posedge clock_in) disable iff (!rst_b_in) record_mode_in && rise.capstan_div);
endmodule

/* File: mscu_capture_bench.sv */
// self-checking bench for the motor servo capture unit
module mscu_capture_bench
  import mscu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic record_mode_in = 1'b0;
  logic [15:0] cmp = 16'hffff;
  logic [4:0] lvl = 5'h00;
  mscu_pulse_s pulse;
  logic [15:0] free_running_count, tmr, dcap, ccap, rcap, pcap, tcap, f, t, keep;
  logic [15:0] model_frc = 16'h0000;
  logic [15:0] model_tmr = 16'h0000;
  logic rsig, dirq, cirq;
  int miscompares = 0;
  int n_compared = 0;
  always #4 clock_in = ~clock_in;
  // expected counts kept apart from the design: free count +1 per clock,
  // timer clears on the cycle after it equals the compare value
  always @(posedge clock_in)
  begin
    model_frc <= rst_b_in ? model_frc + 16'h0001 : 16'h0000;
    if (!rst_b_in || model_tmr == cmp)
      model_tmr <= 16'h0000;
    else
      model_tmr <= model_tmr + 16'h0001;
  end
  mscu_tacho_model u_mscu_tacho_model (.level_in(lvl), .pulse_out(pulse));
  mscu_capture u_mscu_capture (.clock_in(clock_in), .rst_b_in(rst_b_in), .pulse_in(pulse),
    .record_mode_in(record_mode_in), .reference_period_compare_in(cmp), .free_running_count_out(free_running_count),
    .reference_timer_count_out(tmr), .drum_freq_capture_out(dcap), .capstan_freq_capture_out(ccap),
    .reference_capture_out(rcap), .phase_capture_out(pcap), .control_track_capture_out(tcap),
    .reference_signal_out(rsig), .drum_capture_irq_out(dirq), .capstan_capture_irq_out(cirq));
  // ==========================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // raise pulses for one cycle, or leave them high when hold is set, note the counts shown while high
  task automatic strobe(input logic [4:0] m, input bit hold);
    @(posedge clock_in);
    lvl <= m;
    #1 f = model_frc;
    t = model_tmr;
    chk(free_running_count, model_frc);
    chk(tmr, model_tmr);
    @(posedge clock_in);
    if (!hold)
      lvl <= 5'h00;
    #1;
  endtask
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic test_reference();
    @(posedge clock_in);
    cmp <= 16'h0005;
    for (int i = 0; i < 100 && rsig !== 1'b1; i++)
      @(posedge clock_in) #1;
    if (rsig !== 1'b1)
    begin
      miscompares++;
      test_done();
    end
    chk(tmr, 16'h0000);
    chk(rcap, model_frc - 16'h0001);
    repeat (5) @(posedge clock_in);
    #1 chk({15'h0, rsig}, 16'h0000);
    @(posedge clock_in) #1 chk({15'h0, rsig}, 16'h0001);
    chk(rcap, model_frc - 16'h0001);
    $display("reference test done");
  endtask
  task automatic test_drum();
    strobe(5'h10, 1'b1);
    chk(dcap, f);
    chk({14'h0, dirq, cirq}, 16'h0002);
    repeat (3) @(posedge clock_in);
    #1 chk(dcap, f);
    chk({15'h0, dirq}, 16'h0000);
    strobe(5'h04, 1'b0);
    chk(pcap, f);
    $display("drum test done");
  endtask
  task automatic test_capstan();
    strobe(5'h08, 1'b0);
    chk(ccap, f);
    chk({14'h0, dirq, cirq}, 16'h0001);
    strobe(5'h08, 1'b0);
    chk(ccap, f);
    chk({15'h0, cirq}, 16'h0001);
    $display("capstan test done");
  endtask
  task automatic test_track();
    strobe(5'h02, 1'b0);
    chk(tcap, t);
    keep = t;
    strobe(5'h01, 1'b0);
    chk(tcap, keep);
    @(posedge clock_in);
    record_mode_in <= 1'b1;
    strobe(5'h01, 1'b0);
    chk(tcap, t);
    keep = t;
    strobe(5'h02, 1'b0);
    chk(tcap, keep);
    $display("control track test done");
  endtask
  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_b_in <= 1'b1;
    test_reference();
    test_drum();
    test_capstan();
    test_track();
    test_done();
  end
endmodule

/* File: mscu_defs.svh */
// constants for the motor servo capture unit
`ifndef MSCU_DEFS_SVH
`define MSCU_DEFS_SVH
`define MSCU_COUNT_W 16
`define MSCU_FRC_RESET 16'h0000
`define MSCU_TIMER_RESET 16'h0000
`define MSCU_PERIOD_DEFAULT 16'hffff
`endif

/* File: mscu_pkg.sv */
// types for the motor servo capture unit
package mscu_pkg;
  typedef struct packed {
    logic drum_freq;
    logic capstan_freq;
    logic drum_phase;
    logic playback_ct;
    logic capstan_div;
  } mscu_pulse_s;
endpackage

/* File: mscu_tacho_model.sv */
// far-side model: tachometer, phase and sync pulse sources
module mscu_tacho_model
  import mscu_pkg::*;
(
  input wire logic [4:0] level_in,
  output mscu_pulse_s pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // sensors give plain levels; width and spacing come from the bench
  assign pulse_out = mscu_pulse_s'(level_in);
endmodule
